// file: logic/ordc_top.sv
// Contract
// - Coarse code selects coarse cycle factor
// - Zero trim gives nominal rates at 24.576MHz
// - Trim lengthens period by trim times factor, trim clamped at 5FF
// - Fine cycle factor depends on coarse code
// - Divider is coarse times 384 plus fine times trim
// - New rate applies after 16 old periods
// - Register transfer carries exactly 16 bits
`include "ordc_cfg.svh"

module ordc_top
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register write from serial interface
  input wire logic i_wr_valid,
  input wire ordc_pkg::ordc_word_t i_wr_data,
  // Register read back
  output ordc_pkg::ordc_word_t o_rd_data,
  // Converter timing
  output logic o_data_tick,
  output ordc_pkg::ordc_div_t o_period_cycles,
  output logic o_change_pending
);
  import ordc_pkg::*;

  // Register and timing state
  ordc_word_t ctrl_reg;
  ordc_state_t state_reg;
  logic [4:0] settle_reg;
  ordc_div_t div_reg;
  ordc_div_t cnt_reg;
  logic tick_reg;
  // Divider computed from the held control word
  ordc_div_t div_next;
  // Period boundary
  logic period_end;

  // Coarse cycle factor per code
  function automatic logic [7:0] coarse_factor(input ordc_code_t code);
    logic [7:0] f;
    f = 8'h04;
    unique case (code)
      3'h0: f = 8'h04;
      3'h1: f = 8'h80;
      3'h2: f = 8'h40;
      3'h3: f = 8'h20;
      3'h4: f = 8'h10;
      3'h5: f = 8'h08;
      3'h6: f = 8'h02;
      3'h7: f = 8'h01;
    endcase
    return f;
  endfunction

  // Fine cycle factor per code
  function automatic logic [5:0] fine_factor(input ordc_code_t code);
    logic [5:0] f;
    f = 6'h01;
    unique case (code)
      3'h0: f = 6'h01;
      3'h1: f = 6'h20;
      3'h2: f = 6'h10;
      3'h3: f = 6'h08;
      3'h4: f = 6'h04;
      3'h5: f = 6'h02;
      3'h6: f = 6'h01;
      3'h7: f = 6'h01;
    endcase
    return f;
  endfunction

  // Trim codes above the top step add nothing further
  function automatic ordc_trim_t clamp_trim(input ordc_trim_t trim);
    return (trim > `ORDC_TRIM_MAX) ? `ORDC_TRIM_MAX : trim;
  endfunction

  // Divider from a full control word
  function automatic ordc_div_t divider(input ordc_word_t w);
    ordc_code_t code;
    ordc_trim_t trim;
    code = w[`ORDC_COARSE_MSB:`ORDC_COARSE_LSB];
    trim = clamp_trim(w[`ORDC_TRIM_MSB:`ORDC_TRIM_LSB]);
    return ordc_div_t'(coarse_factor(code)) * `ORDC_BASE_MULT
      + ordc_div_t'(fine_factor(code)) * ordc_div_t'(trim);
  endfunction

  // Divider of the most recently written word
  always_comb
  begin
    div_next = divider(ctrl_reg);
  end

  // Last cycle of the running period
  assign period_end = (cnt_reg == div_reg - 17'h00001);

  // Control word; reserved bits are stored as zero
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_reg <= `ORDC_CTRL_RESET;
    end
    else if (i_wr_valid)
    begin
      // Whole 16-bit word in one write
      ctrl_reg <= {i_wr_data[15:13], 2'h0, i_wr_data[10:0]};
    end
  end

  // Read back the held word
  assign o_rd_data = ctrl_reg;

  // Settle sequencing: count old-rate periods after a write
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= ORDC_RUN;
      settle_reg <= 5'h00;
    end
    else if (i_wr_valid)
    begin
      // A fresh write restarts the wait
      state_reg <= ORDC_SETTLE;
      settle_reg <= 5'h00;
    end
    else if (period_end)
    begin
      unique case (state_reg)
        ORDC_RUN:
        begin
          settle_reg <= 5'h00;
        end
        ORDC_SETTLE:
        begin
          if (settle_reg == `ORDC_SETTLE_PERIODS - 5'h01)
          begin
            state_reg <= ORDC_RUN;
            settle_reg <= 5'h00;
          end
          else
          begin
            settle_reg <= settle_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // Active divider: switches only at the sixteenth boundary
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_reg <= `ORDC_DIV_RESET;
    end
    else if (!i_wr_valid && period_end && state_reg == ORDC_SETTLE
             && settle_reg == `ORDC_SETTLE_PERIODS - 5'h01)
    begin
      div_reg <= div_next;
    end
  end

  // Period counter over crystal clock cycles
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end
    else
    begin
      // Wrap at the divider; rate is clock over divider
      cnt_reg <= period_end ? 17'h00000 : cnt_reg + 17'h00001;
      tick_reg <= period_end;
    end
  end

  // Outputs from flip-flops
  assign o_data_tick = tick_reg;
  assign o_period_cycles = div_reg;
  assign o_change_pending = (state_reg == ORDC_SETTLE);

  // Checks: coarse factor table drives the zero-trim divider
  AST_COARSE_ZERO_TRIM: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ctrl_reg[10:0] == 11'h000 && ctrl_reg[15:13] == 3'h1)
      |-> div_next == 17'h0C000)
    else $error("Coarse code 001 does not give 49152 cycles");

  AST_NOMINAL_16K: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ctrl_reg == 16'h0000) |-> (`ORDC_XIN_HZ / 16000) == int'(div_next))
    else $error("Code 000 does not give 16 ksps");

  AST_NOMINAL_64K: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ctrl_reg == 16'hE000) |-> (`ORDC_XIN_HZ / 64000) == int'(div_next))
    else $error("Code 111 does not give 64 ksps");

  AST_TRIM_STEP: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ctrl_reg[15:13] == 3'h1 && ctrl_reg[10:0] == 11'h001) |-> div_next == 17'h0C020)
    else $error("Trim step at code 001 is not 32 cycles");

  AST_FINE_FACTOR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ctrl_reg[15:13] == 3'h4 && ctrl_reg[10:0] == 11'h5FF) |-> div_next == 17'h02FFC)
    else $error("Full trim at code 100 is not 12284 cycles");

  AST_PERIOD_SPACING: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cnt_reg < div_reg && (!tick_reg || cnt_reg == 17'h00000))
    else $error("Period counter left its divider range");

  AST_HOLD_OLD_RATE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (div_reg != $past(div_reg)) |-> ($past(settle_reg) == 5'h0F && $past(period_end)))
    else $error("Divider changed before sixteen old periods");

  AST_WORD_16BIT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_wr_valid |=> o_rd_data == {$past(i_wr_data[15:13]), 2'h0, $past(i_wr_data[10:0])})
    else $error("Read back differs from written word");

endmodule

// file: logic/ordc_cfg.svh
`ifndef ORDC_CFG_SVH
`define ORDC_CFG_SVH

// Field positions of the rate control word
`define ORDC_COARSE_MSB 15
`define ORDC_COARSE_LSB 13
`define ORDC_TRIM_MSB 10
`define ORDC_TRIM_LSB 0

// Reset value of the rate control word (coarse 000, trim 0)
`define ORDC_CTRL_RESET 16'h0000

// Divider arithmetic
`define ORDC_BASE_MULT 17'h00180
`define ORDC_TRIM_MAX 11'h5FF
`define ORDC_DIV_RESET 17'h00600

// Periods at the old rate before a new setting applies
`define ORDC_SETTLE_PERIODS 5'h10

// Reference crystal rate for nominal output rates, in Hz
`define ORDC_XIN_HZ 24576000

`endif

// file: logic/ordc_pkg.sv
package ordc_pkg;
  // Coarse rate code
  typedef logic [2:0] ordc_code_t;
  // Fine period trim
  typedef logic [10:0] ordc_trim_t;
  // Output period in crystal clock cycles
  typedef logic [16:0] ordc_div_t;
  // Rate control word
  typedef logic [15:0] ordc_word_t;
  // Rate change sequencing
  typedef enum logic {ORDC_RUN, ORDC_SETTLE} ordc_state_t;
endpackage

// file: tb/ordc_host.sv
// Host side: sends whole rate words with reserved bits cleared
module ordc_host
(
  // Clock and request from bench
  input wire logic i_clk,
  input wire logic i_req,
  input wire ordc_pkg::ordc_word_t i_word,
  // Register write toward the block
  output logic o_wr_valid,
  output ordc_pkg::ordc_word_t o_wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  import ordc_pkg::*;
  // One-cycle write; idle data toggles so it is never trusted
  initial
  begin
    o_wr_valid = 1'b0;
    o_wr_data = 16'h0000;
    forever
    begin
      @(posedge i_clk);
      o_wr_valid <= i_req;
      o_wr_data <= i_req ? (i_word & 16'hE7FF) : ~o_wr_data;
    end
  end
endmodule

// file: tb/output_rate_divider_control_test.sv
module output_rate_divider_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ordc_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, req = 1'b0, wv, tk, pend;
  ordc_word_t word = 16'h0000, wd, rd;
  ordc_div_t per;
  int n_fail = 0, compares = 0, g;
  // Coarse and fine cycle factors by code
  int cf[8] = '{4, 128, 64, 32, 16, 8, 2, 1};
  int ff[8] = '{1, 32, 16, 8, 4, 2, 1, 1};
  // Words written in turn; each after the first lands while a change is pending and restarts the wait
  ordc_word_t ws[5] = '{16'h2000, 16'h2001, 16'h85FF, 16'hE000, 16'hA000};
  // Clock, 4 ns
  always #2 i_clk = ~i_clk;
  ordc_host host (.i_clk(i_clk), .i_req(req), .i_word(word), .o_wr_valid(wv), .o_wr_data(wd));
  ordc_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wr_valid(wv), .i_wr_data(wd),
    .o_rd_data(rd), .o_data_tick(tk), .o_period_cycles(per), .o_change_pending(pend));
  // Value compare
  task chk(string nm, logic [16:0] e, logic [16:0] s);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask
  // Verdict and end of run
  task complete_run();
    $display("checks %0d wrong %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Expected divider, trim clamped
  function automatic ordc_div_t xdiv(ordc_word_t w);
    int t;
    t = (w[10:0] > 11'h5FF) ? 11'h5FF : w[10:0];
    return ordc_div_t'(cf[w[15:13]] * 384 + ff[w[15:13]] * t);
  endfunction
  // Host write, checked on read back
  task wr(ordc_word_t w);
    @(posedge i_clk) #1 req = 1'b1;
    word = w;
    @(posedge i_clk) #1 req = 1'b0;
    @(posedge i_clk) #1;
    chk("rd", {1'b0, w & 16'hE7FF}, {1'b0, rd});
    chk("pend", 17'h00001, {16'h0000, pend});
  endtask
  // Next tick, gap in cycles
  task tick();
    g = 0;
    do
    begin
      @(posedge i_clk) #1 g++;
    end
    while (tk !== 1'b1 && g < 60000);
    if (g >= 60000)
    begin
      n_fail++;
      complete_run();
    end
  endtask
  // Rate change walk
  task go(ordc_word_t w);
    ordc_div_t od;
    od = per;
    tick();
    wr(w);
    chk("old", od, per);
    repeat (15) tick();
    chk("wait", 17'h00001, {16'h0000, pend});
    tick();
    chk("gap", od, 17'(g));
    chk("div", xdiv(w), per);
    chk("done", 17'h00000, {16'h0000, pend});
    tick();
    chk("new", xdiv(w), 17'(g));
    $display("rate %h done", w);
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    chk("rst rd", 17'h00000, {1'b0, rd});
    chk("rst div", 17'h00600, per);
    tick();
    tick();
    chk("rst gap", 17'h00600, 17'(g));
    $display("reset done");
    // Writes during pending restart the wait
    for (int c = 0; c < 5; c++)
    begin
      wr(ws[c]);
      repeat (2) tick();
    end
    $display("restart done");
    go(16'hE001);
    go(16'hC100);
    go(16'h1FFF);
    // Reset in mid-run drops a pending setting
    wr(16'h4000);
    @(posedge i_clk) #1 i_resetn = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    chk("rst2 rd", 17'h00000, {1'b0, rd});
    chk("rst2 pend", 17'h00000, {16'h0000, pend});
    chk("rst2 div", 17'h00600, per);
    tick();
    chk("rst2 gap", 17'h00600, 17'(g));
    $display("reset again done");
    complete_run();
  end
endmodule
